// *** rtl/uefc_consts.svh ***
// constants for the usb endpoint buffer and control logic
`ifndef UEFC_CONSTS_SVH
`define UEFC_CONSTS_SVH
`define UEFC_NUM_EP 5
`define UEFC_BUF_BYTES 32
`define UEFC_PTR_W 5
`define UEFC_HALF_BUF 8'h10
`define UEFC_EP0_LARGEST_PACKET_BYTES_RST 8'h08
`define UEFC_EPX_LARGEST_PACKET_BYTES_RST 8'h00
`define UEFC_CTL_RST 8'h00
`define UEFC_REG_CSR 3'h0
`define UEFC_REG_OCSR 3'h1
`define UEFC_REG_IMAXP 3'h2
`define UEFC_REG_OMAXP 3'h3
`define UEFC_REG_CNT 3'h4
`define UEFC_REG_DATA 3'h5
`define UEFC_B_PKT 0
`define UEFC_B_RUN 1
`define UEFC_B_STALL 2
`define UEFC_B_ISO 3
`define UEFC_B_B4 4
`define UEFC_B_B5 5
`define UEFC_B_FLUSH 6
`define UEFC_B_AUTO 7
`define UEFC_E0_TXRDY 1
`define UEFC_E0_RXREL 6
`define UEFC_E0_ENDREL 7
`endif

// *** rtl/uefc_pkg.sv ***
// shared types of the usb endpoint buffer and control logic
package uefc_pkg;
`include "uefc_consts.svh"
	typedef logic [7:0] uefc_byte_type;
	typedef logic [`UEFC_PTR_W-1:0] uefc_ptr_type;
endpackage : uefc_pkg

// *** rtl/uefc_top.sv ***
// endpoint control, status and packet buffers of a full-speed usb function
// Functional notes
// - endpoint 0: writing one to bit 6 or 7 clears rx-ready or early-end
// - endpoint 0 largest packet size resets to 8, used both directions
// - good OUT packet loads its byte count for the cpu to read
// - tx loaded write and each sent packet update pointers and status
// - iso IN token with empty buffer sets underrun and shared interrupt
// - stall request bit makes its own direction answer STALL; the endpoint 0 bit stalls both
// - iso IN endpoint always sends DATA0
// - setting then clearing iso bit resets the data toggle to DATA0
// - interrupt-type bit makes IN endpoint a status-change endpoint
// - tx occupied bit is one while a whole packet is buffered
// - flush empties one packet or drops the older of two
// - auto-arm sets tx loaded after a full packet is written
// - good OUT packet sets rx waiting; cpu writing zero releases it
// - iso OUT token with two packets held sets overrun and interrupt
// - iso OUT endpoint accepts DATA0 or DATA1
// - oversize OUT packet sets forced stall until cpu writes zero
// - iso packet with crc or stuffing error sets data error flag
// - auto-release clears rx waiting after a full packet is read
// - single buffering for endpoint 0 or when size above half buffer, else dual
// - endpoints 1-4 largest packet sizes reset to zero
// - data port writes fill tx buffer, reads drain rx buffer
`timescale 1ns/1ps
`include "uefc_consts.svh"
module uefc_top import uefc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] sie_ep_i,
	input wire logic sie_in_token_i,
	input wire logic sie_out_token_i,
	input wire logic sie_tx_rd_i,
	input wire logic sie_tx_done_i,
	input wire logic sie_rx_wr_i,
	input wire logic [7:0] sie_rx_data_i,
	input wire logic sie_rx_ok_i,
	input wire logic sie_rx_bad_i,
	input wire logic sie_setup_end_i,
	output logic [7:0] sie_tx_data_o,
	output logic [7:0] sie_tx_len_o,
	output logic sie_tx_ready_o,
	output logic sie_tx_pid1_o,
	output logic sie_rx_pid1_o,
	output logic sie_rx_any_pid_o,
	output logic sie_rx_room_o,
	output logic sie_in_stall_o,
	output logic sie_out_stall_o,
	output logic status_change_endpoint_o,
	output logic shared_iso_error_interrupt_o
);
	localparam int NE = `UEFC_NUM_EP;
	localparam int NB = `UEFC_BUF_BYTES;

	// packets that fit: one when size is above half the buffer
	function automatic logic [1:0] cap_f(input uefc_byte_type m);
		return (m > `UEFC_HALF_BUF) ? 2'h1 : 2'h2;
	endfunction : cap_f

	// circular pointer step by a byte count
	function automatic uefc_ptr_type adv_f(input uefc_ptr_type p,
		input uefc_byte_type n);
		return p + n[`UEFC_PTR_W-1:0];
	endfunction : adv_f

	uefc_byte_type tx_mem [NE][NB];
	uefc_byte_type rx_mem [NE][NB];
	uefc_byte_type in_largest_packet_bytes_reg [NE];
	uefc_byte_type out_largest_packet_bytes_reg [NE];
	logic [7:0] in_ctl_reg [NE];
	logic [7:0] out_ctl_reg [NE];
	logic e0_early_reg;
	uefc_ptr_type tx_wp_reg [NE];
	uefc_ptr_type tx_rb_reg [NE];
	uefc_ptr_type tx_ro_reg [NE];
	uefc_byte_type tx_cur_reg [NE];
	uefc_byte_type tx_len_reg [NE][2];
	logic [1:0] tx_n_reg [NE];
	logic tx_hd_reg [NE];
	uefc_ptr_type rx_wb_reg [NE];
	uefc_ptr_type rx_rb_reg [NE];
	uefc_ptr_type rx_ro_reg [NE];
	uefc_byte_type rx_wo_reg [NE];
	uefc_byte_type rx_len_reg [NE][2];
	logic [1:0] rx_n_reg [NE];
	logic rx_hd_reg [NE];
	logic [NE-1:0] tx_tg_reg;
	logic [NE-1:0] rx_tg_reg;
	logic [NE-1:0] iso_in_prev_reg;
	logic [NE-1:0] iso_out_prev_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic irq_reg;
	uefc_byte_type sdat_reg;
	uefc_byte_type slen_reg;

	logic acc, wr, rd, a_hit;
	logic [2:0] a_ep, a_rg, ai, si;
	uefc_byte_type d, rdata;
	uefc_byte_type rmax [NE];
	logic [1:0] tcap [NE];
	logic [1:0] rcap [NE];
	logic [NE-1:0] tx_byte, tx_push, tx_pop, tx_rd;
	logic [NE-1:0] rx_rd, rx_pop, rx_byte, rx_acc, rx_big;
	logic [NE-1:0] tx_done, under_set, over_set, derr_set;
	logic [NE-1:0] w_csr, w_ocsr;

	// bus decode: the access acts on the edge that shows ack
	assign acc = wb_cyc_i & wb_stb_i & ack_reg & ce_i;
	assign wr = acc & wb_we_i & wb_sel_i[0];
	assign rd = acc & ~wb_we_i;
	assign a_ep = wb_adr_i[7:5];
	assign a_rg = wb_adr_i[4:2];
	assign a_hit = (a_ep < 3'(NE)) && (wb_adr_i[1:0] == 2'h0);
	assign ai = a_hit ? a_ep : 3'h0;
	assign si = (sie_ep_i < 3'(NE)) ? sie_ep_i : 3'h0;
	assign d = wb_dat_i[7:0];

	// per endpoint events from the cpu port and the serial engine
	always_comb begin
		for (int e = 0; e < NE; e++) begin
			rmax[e] = (e == 0) ? in_largest_packet_bytes_reg[0] : out_largest_packet_bytes_reg[e];
			tcap[e] = (e == 0) ? 2'h1 : cap_f(in_largest_packet_bytes_reg[e]);
			rcap[e] = (e == 0) ? 2'h1 : cap_f(rmax[e]);
			w_csr[e] = wr && a_hit && a_ep == 3'(e) && a_rg == `UEFC_REG_CSR;
			w_ocsr[e] = wr && a_hit && a_ep == 3'(e) && e != 0
				&& a_rg == `UEFC_REG_OCSR;
			tx_byte[e] = wr && a_hit && a_ep == 3'(e)
				&& a_rg == `UEFC_REG_DATA;
			rx_rd[e] = rd && a_hit && a_ep == 3'(e)
				&& a_rg == `UEFC_REG_DATA && rx_n_reg[e] != 2'h0;
			tx_push[e] = (w_csr[e] && d[(e == 0) ? `UEFC_E0_TXRDY
				: `UEFC_B_PKT]) || (tx_byte[e] && e != 0
				&& in_ctl_reg[e][`UEFC_B_AUTO]
				&& tx_cur_reg[e] + 8'h01 == in_largest_packet_bytes_reg[e]);
			tx_done[e] = sie_tx_done_i && si == 3'(e);
			tx_pop[e] = (tx_done[e] || (w_csr[e] && e != 0
				&& d[`UEFC_B_FLUSH])) && tx_n_reg[e] != 2'h0;
			tx_rd[e] = sie_tx_rd_i && si == 3'(e);
			rx_pop[e] = ((w_csr[e] && e == 0 && d[`UEFC_E0_RXREL])
				|| (w_ocsr[e] && (!d[`UEFC_B_PKT] || d[`UEFC_B_FLUSH]))
				|| (rx_rd[e] && e != 0 && out_ctl_reg[e][`UEFC_B_AUTO]
				&& {3'h0, rx_ro_reg[e]} + 8'h01 == rmax[e]))
				&& rx_n_reg[e] != 2'h0;
			rx_byte[e] = sie_rx_wr_i && si == 3'(e);
			rx_big[e] = sie_rx_ok_i && si == 3'(e)
				&& rx_wo_reg[e] > rmax[e];
			rx_acc[e] = sie_rx_ok_i && si == 3'(e) && !rx_big[e]
				&& rx_n_reg[e] < rcap[e];
			under_set[e] = sie_in_token_i && si == 3'(e) && e != 0
				&& in_ctl_reg[e][`UEFC_B_ISO]
				&& tx_n_reg[e] == 2'h0;
			over_set[e] = sie_out_token_i && si == 3'(e) && e != 0
				&& out_ctl_reg[e][`UEFC_B_ISO]
				&& rx_n_reg[e] == 2'h2;
			derr_set[e] = sie_rx_bad_i && si == 3'(e) && e != 0
				&& out_ctl_reg[e][`UEFC_B_ISO];
		end
	end

	// transmit buffer pointers and packet bookkeeping
	always_ff @(posedge clk_i) begin
		for (int e = 0; e < NE; e++) begin
			if (rst_i) begin
				tx_wp_reg[e] <= '0;
				tx_rb_reg[e] <= '0;
				tx_ro_reg[e] <= '0;
				tx_cur_reg[e] <= 8'h00;
				tx_len_reg[e][0] <= 8'h00;
				tx_len_reg[e][1] <= 8'h00;
				tx_n_reg[e] <= 2'h0;
				tx_hd_reg[e] <= 1'b0;
			end else if (ce_i) begin
				if (tx_byte[e]) begin
					tx_wp_reg[e] <= tx_wp_reg[e] + 1'b1;
					tx_cur_reg[e] <= tx_cur_reg[e] + 8'h01;
				end
				if (tx_rd[e]) begin
					tx_ro_reg[e] <= tx_ro_reg[e] + 1'b1;
				end
				if (tx_push[e] && tx_n_reg[e] < tcap[e]) begin
					tx_len_reg[e][tx_hd_reg[e] ^ tx_n_reg[e][0]] <=
						tx_cur_reg[e] + (tx_byte[e] ? 8'h01 : 8'h00);
					tx_cur_reg[e] <= 8'h00;
				end
				if (tx_pop[e]) begin
					tx_rb_reg[e] <= adv_f(tx_rb_reg[e],
						tx_len_reg[e][tx_hd_reg[e]]);
					tx_ro_reg[e] <= '0;
					tx_hd_reg[e] <= ~tx_hd_reg[e];
				end
				tx_n_reg[e] <= tx_n_reg[e]
					+ {1'b0, tx_push[e] && tx_n_reg[e] < tcap[e]}
					- {1'b0, tx_pop[e]};
			end
		end
	end

	// receive buffer pointers, counts and packet bookkeeping
	always_ff @(posedge clk_i) begin
		for (int e = 0; e < NE; e++) begin
			if (rst_i) begin
				rx_wb_reg[e] <= '0;
				rx_rb_reg[e] <= '0;
				rx_ro_reg[e] <= '0;
				rx_wo_reg[e] <= 8'h00;
				rx_len_reg[e][0] <= 8'h00;
				rx_len_reg[e][1] <= 8'h00;
				rx_n_reg[e] <= 2'h0;
				rx_hd_reg[e] <= 1'b0;
			end else if (ce_i) begin
				if (rx_byte[e] && rx_wo_reg[e] != 8'hFF) begin
					rx_wo_reg[e] <= rx_wo_reg[e] + 8'h01;
				end
				if ((sie_out_token_i || sie_rx_ok_i || sie_rx_bad_i)
					&& si == 3'(e)) begin
					rx_wo_reg[e] <= 8'h00; // bad or refused data is dropped
				end
				if (rx_acc[e]) begin
					rx_len_reg[e][rx_hd_reg[e] ^ rx_n_reg[e][0]] <=
						rx_wo_reg[e];
					rx_wb_reg[e] <= adv_f(rx_wb_reg[e], rx_wo_reg[e]);
				end
				if (rx_rd[e]) begin
					rx_ro_reg[e] <= rx_ro_reg[e] + 1'b1;
				end
				if (rx_pop[e]) begin
					rx_rb_reg[e] <= adv_f(rx_rb_reg[e],
						rx_len_reg[e][rx_hd_reg[e]]);
					rx_ro_reg[e] <= '0;
					rx_hd_reg[e] <= ~rx_hd_reg[e];
				end
				rx_n_reg[e] <= rx_n_reg[e] + {1'b0, rx_acc[e]}
					- {1'b0, rx_pop[e]};
			end
		end
	end

	// byte storage; tx bytes always written, rx bytes only while the receive side has room
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			for (int e = 0; e < NE; e++) begin
				if (tx_byte[e]) begin
					tx_mem[e][tx_wp_reg[e]] <= d;
				end
				if (rx_byte[e] && rx_n_reg[e] < rcap[e]
					&& rx_wo_reg[e] < rmax[e]) begin
					rx_mem[e][adv_f(rx_wb_reg[e], rx_wo_reg[e])] <=
						sie_rx_data_i;
				end
			end
		end
	end

	// control bits, sticky flags and packet size settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			e0_early_reg <= 1'b0;
			for (int e = 0; e < NE; e++) begin
				in_ctl_reg[e] <= `UEFC_CTL_RST;
				out_ctl_reg[e] <= `UEFC_CTL_RST;
				in_largest_packet_bytes_reg[e] <= (e == 0) ? `UEFC_EP0_LARGEST_PACKET_BYTES_RST
					: `UEFC_EPX_LARGEST_PACKET_BYTES_RST;
				out_largest_packet_bytes_reg[e] <= `UEFC_EPX_LARGEST_PACKET_BYTES_RST;
			end
		end else if (ce_i) begin
			if (w_csr[0] && d[`UEFC_E0_ENDREL]) begin
				e0_early_reg <= 1'b0;
			end
			if (sie_setup_end_i) begin
				e0_early_reg <= 1'b1;
			end
			for (int e = 0; e < NE; e++) begin
				if (w_csr[e]) begin
					in_ctl_reg[e][`UEFC_B_STALL] <= d[`UEFC_B_STALL];
					in_ctl_reg[e][`UEFC_B_ISO] <= d[`UEFC_B_ISO];
					if (e != 0) begin
						in_ctl_reg[e][`UEFC_B_B4] <= d[`UEFC_B_B4];
						in_ctl_reg[e][`UEFC_B_AUTO] <= d[`UEFC_B_AUTO];
						if (!d[`UEFC_B_RUN]) begin
							in_ctl_reg[e][`UEFC_B_RUN] <= 1'b0;
						end
					end else if (!d[`UEFC_B_B4]) begin
						out_ctl_reg[0][`UEFC_B_B4] <= 1'b0;
					end
				end
				if (w_ocsr[e]) begin
					out_ctl_reg[e][`UEFC_B_STALL] <= d[`UEFC_B_STALL];
					out_ctl_reg[e][`UEFC_B_ISO] <= d[`UEFC_B_ISO];
					out_ctl_reg[e][`UEFC_B_AUTO] <= d[`UEFC_B_AUTO];
					for (int b = `UEFC_B_RUN; b <= `UEFC_B_B5; b++) begin
						if (b != `UEFC_B_STALL && b != `UEFC_B_ISO && !d[b]) begin
							out_ctl_reg[e][b] <= 1'b0;
						end
					end
				end
				if (wr && a_hit && a_ep == 3'(e) && a_rg == `UEFC_REG_IMAXP) begin
					in_largest_packet_bytes_reg[e] <= d;
				end
				if (wr && a_hit && a_ep == 3'(e) && e != 0
					&& a_rg == `UEFC_REG_OMAXP) begin
					out_largest_packet_bytes_reg[e] <= d;
				end
				// hardware sets win over a clear in the same cycle
				if (under_set[e]) begin
					in_ctl_reg[e][`UEFC_B_RUN] <= 1'b1;
				end
				if (over_set[e]) begin
					out_ctl_reg[e][`UEFC_B_RUN] <= 1'b1;
				end
				if (rx_big[e]) begin
					out_ctl_reg[e][`UEFC_B_B4] <= 1'b1;
				end
				if (derr_set[e]) begin
					out_ctl_reg[e][`UEFC_B_B5] <= 1'b1;
				end
			end
		end
	end

	// data toggles; a falling iso bit reinitialises to DATA0
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_tg_reg <= '0;
			rx_tg_reg <= '0;
			iso_in_prev_reg <= '0;
			iso_out_prev_reg <= '0;
		end else if (ce_i) begin
			for (int e = 0; e < NE; e++) begin
				iso_in_prev_reg[e] <= in_ctl_reg[e][`UEFC_B_ISO];
				iso_out_prev_reg[e] <= out_ctl_reg[e][`UEFC_B_ISO];
				if (iso_in_prev_reg[e] && !in_ctl_reg[e][`UEFC_B_ISO]) begin
					tx_tg_reg[e] <= 1'b0;
				end else if (tx_done[e] && !in_ctl_reg[e][`UEFC_B_ISO]) begin
					tx_tg_reg[e] <= ~tx_tg_reg[e];
				end
				if (iso_out_prev_reg[e] && !out_ctl_reg[e][`UEFC_B_ISO]) begin
					rx_tg_reg[e] <= 1'b0;
				end else if (rx_acc[e]) begin
					rx_tg_reg[e] <= ~rx_tg_reg[e];
				end
			end
		end
	end

	// register read view of the addressed endpoint
	always_comb begin
		rdata = 8'h00;
		if (a_hit) begin
			unique case (a_rg)
				`UEFC_REG_CSR: begin
					if (ai == 3'h0) begin
						rdata = {2'h0, e0_early_reg, out_ctl_reg[0][`UEFC_B_B4],
							in_ctl_reg[0][`UEFC_B_ISO], in_ctl_reg[0][`UEFC_B_STALL],
							tx_n_reg[0] != 2'h0, rx_n_reg[0] != 2'h0};
					end else begin
						rdata = {in_ctl_reg[ai][`UEFC_B_AUTO], 1'b0,
							tx_n_reg[ai] != 2'h0,
							in_ctl_reg[ai][4:1],
							tx_n_reg[ai] == tcap[ai]};
					end
				end
				`UEFC_REG_OCSR: begin
					if (ai != 3'h0) begin
						rdata = {out_ctl_reg[ai][`UEFC_B_AUTO], 1'b0,
							out_ctl_reg[ai][5:1], rx_n_reg[ai] != 2'h0};
					end
				end
				`UEFC_REG_IMAXP: rdata = in_largest_packet_bytes_reg[ai];
				`UEFC_REG_OMAXP: rdata = (ai != 3'h0) ? out_largest_packet_bytes_reg[ai] : 8'h00;
				`UEFC_REG_CNT: begin
					if (rx_n_reg[ai] != 2'h0) begin
						rdata = rx_len_reg[ai][rx_hd_reg[ai]];
					end
				end
				`UEFC_REG_DATA: begin
					rdata = rx_mem[ai][adv_f(rx_rb_reg[ai],
						{3'h0, rx_ro_reg[ai]})];
				end
				default: rdata = 8'h00;
			endcase
		end
	end

	// wishbone slave: ack one cycle after the request, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
			if (wb_cyc_i && wb_stb_i && !ack_reg) begin
				dat_reg <= {24'h00_0000, rdata};
			end
		end
	end

	// serial side data and the shared iso error event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sdat_reg <= 8'h00;
			slen_reg <= 8'h00;
			irq_reg <= 1'b0;
		end else if (ce_i) begin
			if (sie_tx_rd_i) begin
				sdat_reg <= tx_mem[si][adv_f(tx_rb_reg[si],
					{3'h0, tx_ro_reg[si]})];
			end
			slen_reg <= (tx_n_reg[si] != 2'h0)
				? tx_len_reg[si][tx_hd_reg[si]] : 8'h00;
			irq_reg <= |(under_set | over_set);
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign sie_tx_data_o = sdat_reg;
	assign sie_tx_len_o = slen_reg;
	assign shared_iso_error_interrupt_o = irq_reg;

	// handshake steering for the endpoint the serial engine selects
	assign sie_tx_ready_o = tx_n_reg[si] != 2'h0;
	assign sie_tx_pid1_o = tx_tg_reg[si]
		& ~in_ctl_reg[si][`UEFC_B_ISO];
	assign sie_rx_pid1_o = rx_tg_reg[si];
	assign sie_rx_any_pid_o = out_ctl_reg[si][`UEFC_B_ISO];
	assign sie_rx_room_o = rx_n_reg[si] < rcap[si];
	assign sie_in_stall_o = in_ctl_reg[si][`UEFC_B_STALL]
		| ((si == 3'h0) & out_ctl_reg[0][`UEFC_B_B4]);
	assign sie_out_stall_o = ((si == 3'h0) ? in_ctl_reg[0][`UEFC_B_STALL]
		: out_ctl_reg[si][`UEFC_B_STALL])
		| out_ctl_reg[si][`UEFC_B_B4];
	assign status_change_endpoint_o = (si != 3'h0)
		& in_ctl_reg[si][`UEFC_B_B4];
endmodule : uefc_top

// *** verification/uefc_props.sv ***
// port-level assertions for the usb endpoint control block
`timescale 1ns/1ps
module uefc_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic [2:0] sie_ep_i,
	input wire logic sie_in_token_i,
	input wire logic sie_out_token_i,
	input wire logic sie_tx_pid1_o,
	input wire logic sie_rx_any_pid_o,
	input wire logic sie_in_stall_o,
	input wire logic sie_out_stall_o,
	input wire logic status_change_endpoint_o,
	input wire logic shared_iso_error_interrupt_o
);
	logic hit;
	// accepted byte write to any register of endpoint 1-4 that the serial engine points at
	assign hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
		&& wb_adr_i[1:0] == 2'h0 && wb_adr_i[7:5] == sie_ep_i
		&& sie_ep_i != 3'h0 && sie_ep_i < 3'h5;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_rise;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("ack late");
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack long");
	property p_in_stall;
		hit && wb_adr_i[4:2] == 3'h0 && wb_dat_i[2]
			|=> sie_in_stall_o || !$stable(sie_ep_i);
	endproperty
	a_in_stall: assert property (p_in_stall) else $error("no in stall");
	property p_out_stall;
		hit && wb_adr_i[4:2] == 3'h1 && wb_dat_i[2]
			|=> sie_out_stall_o || !$stable(sie_ep_i);
	endproperty
	a_out_stall: assert property (p_out_stall) else $error("no stall");
	property p_iso_pid;
		hit && wb_adr_i[4:2] == 3'h0 && wb_dat_i[3]
			|=> !sie_tx_pid1_o || !$stable(sie_ep_i);
	endproperty
	a_iso_pid: assert property (p_iso_pid) else $error("iso sent data1");
	property p_any_pid;
		hit && wb_adr_i[4:2] == 3'h1 && wb_dat_i[3]
			|=> sie_rx_any_pid_o || !$stable(sie_ep_i);
	endproperty
	a_any_pid: assert property (p_any_pid) else $error("iso pid strict");
	property p_stat_chg;
		hit && wb_adr_i[4:2] == 3'h0 && wb_dat_i[4]
			|=> status_change_endpoint_o || !$stable(sie_ep_i);
	endproperty
	a_stat_chg: assert property (p_stat_chg) else $error("no status");
	property p_irq_cause;
		shared_iso_error_interrupt_o
			|-> $past(sie_in_token_i) || $past(sie_out_token_i);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
	c_irq: cover property (shared_iso_error_interrupt_o);
	c_stall: cover property (sie_out_stall_o);
	c_stat: cover property (status_change_endpoint_o);
endmodule : uefc_props
bind uefc_top uefc_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .sie_ep_i(sie_ep_i), .sie_in_token_i(sie_in_token_i),
	.sie_out_token_i(sie_out_token_i), .sie_tx_pid1_o(sie_tx_pid1_o),
	.sie_rx_any_pid_o(sie_rx_any_pid_o), .sie_in_stall_o(sie_in_stall_o),
	.sie_out_stall_o(sie_out_stall_o),
	.status_change_endpoint_o(status_change_endpoint_o),
	.shared_iso_error_interrupt_o(shared_iso_error_interrupt_o));

// *** verification/uefc_host_model.sv ***
// behavioural usb host driving the serial side of the endpoint block
`timescale 1ns/1ps
module uefc_host_model (
	input wire logic clk_i,
	input wire logic [7:0] tx_data_i,
	output logic [2:0] ep_o,
	output logic in_token_o,
	output logic out_token_o,
	output logic tx_rd_o,
	output logic tx_done_o,
	output logic rx_wr_o,
	output logic [7:0] rx_data_o,
	output logic rx_ok_o,
	output logic rx_bad_o,
	output logic setup_end_o
);
	// bus idle at time zero
	initial begin
		{ep_o, in_token_o, out_token_o, tx_rd_o, tx_done_o} = '0;
		{rx_wr_o, rx_data_o, rx_ok_o, rx_bad_o, setup_end_o} = '0;
	end
	// aim the engine at one endpoint
	task automatic point(input logic [2:0] ep);
		ep_o <= ep;
	endtask : point
	// token, numbered bytes, then a clean or damaged packet end
	task automatic out_pkt(input logic [2:0] ep, input int n,
		input logic [7:0] d0, input logic bad);
		ep_o <= ep;
		out_token_o <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			out_token_o <= 1'b0;
			rx_wr_o <= 1'b1;
			rx_data_o <= 8'(d0 + i);
		end
		@(posedge clk_i);
		out_token_o <= 1'b0;
		rx_wr_o <= 1'b0;
		rx_data_o <= ~rx_data_o; // released line does not keep its value
		rx_ok_o <= !bad;
		rx_bad_o <= bad;
		@(posedge clk_i);
		rx_ok_o <= 1'b0;
		rx_bad_o <= 1'b0;
	endtask : out_pkt
	// token, fetch n bytes, optionally acknowledge the packet
	task automatic in_pkt(input logic [2:0] ep, input int n,
		input logic ack, output logic [31:0] q);
		q = 32'h0;
		ep_o <= ep;
		in_token_o <= 1'b1;
		@(posedge clk_i);
		in_token_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			tx_rd_o <= 1'b1;
			@(posedge clk_i);
			tx_rd_o <= 1'b0;
			@(posedge clk_i);
			q[8*i +: 8] = tx_data_i;
		end
		tx_done_o <= ack;
		@(posedge clk_i);
		tx_done_o <= 1'b0;
	endtask : in_pkt
	// early end of a control transfer
	task automatic end_ctl();
		setup_end_o <= 1'b1;
		@(posedge clk_i);
		setup_end_o <= 1'b0;
	endtask : end_ctl
endmodule : uefc_host_model

// *** verification/tb_usb_endpoint_fifo_control.sv ***
// self-checking bench for the usb endpoint control block
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_usb_endpoint_fifo_control;
	logic clk_i, rst_i, cyc, stb, we, ack, itok, otok, rd, done, wr_b;
	logic ok, bad, send, trdy, pid1, rpid1, anyp, istl, ostl, stc, irq;
	logic room;
	logic [2:0] ep;
	logic [3:0] sel;
	logic [7:0] adr, rxd, txd, tlen;
	logic [31:0] wdat, rdat, q, hq;
	int miscompares, n_compared;
	int irq_n = 0;
	uefc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sie_ep_i(ep),
		.sie_in_token_i(itok), .sie_out_token_i(otok), .sie_tx_rd_i(rd),
		.sie_tx_done_i(done), .sie_rx_wr_i(wr_b), .sie_rx_data_i(rxd),
		.sie_rx_ok_i(ok), .sie_rx_bad_i(bad), .sie_setup_end_i(send),
		.sie_tx_data_o(txd), .sie_tx_len_o(tlen), .sie_tx_ready_o(trdy),
		.sie_tx_pid1_o(pid1), .sie_rx_pid1_o(rpid1), .sie_rx_any_pid_o(anyp),
		.sie_rx_room_o(room), .sie_in_stall_o(istl), .sie_out_stall_o(ostl),
		.status_change_endpoint_o(stc), .shared_iso_error_interrupt_o(irq));
	uefc_host_model host (.clk_i(clk_i), .tx_data_i(txd), .ep_o(ep),
		.in_token_o(itok), .out_token_o(otok), .tx_rd_o(rd), .tx_done_o(done),
		.rx_wr_o(wr_b), .rx_data_o(rxd), .rx_ok_o(ok), .rx_bad_o(bad),
		.setup_end_o(send));
	// 100 ns clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// count shared interrupt pulses; each lasts one cycle
	always @(posedge clk_i) begin
		if (irq === 1'b1) begin
			irq_n <= irq_n + 1;
		end
	end
	// count and compare
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// verdict and end of run
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	// one classic wishbone cycle, held until ack, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 16) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 16) begin
			miscompares++;
			report_and_stop();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i); // idle cycle before any read back
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		`CHK(q, e);
	endtask : rc
	// endpoint base plus register slot
	function automatic logic [7:0] ra(input int e, input int r);
		return 8'(e * 32 + r * 4);
	endfunction : ra
	// main sequence
	initial begin
		{rst_i, cyc, stb, we, adr, wdat, sel} = {3'h4, 41'h0, 4'hF};
		miscompares = 0;
		n_compared = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int e = 0; e < 5; e++) begin
			rc(ra(e, 2), e == 0 ? 8'h08 : 8'h00);
			rc(ra(e, 3), 8'h00);
		end
		rc(8'hA8, 8'h00);
		`CHK(room, 1'b1);
		$display("test reset values done");
		host.point(3'h1);
		wr(ra(1, 3), 8'h03);
		wr(ra(1, 1), 8'h80);
		host.out_pkt(3'h1, 3, 8'hA0, 1'b0);
		rc(ra(1, 1), 8'h81);
		rc(ra(1, 4), 8'h03);
		for (int i = 0; i < 3; i++) rc(ra(1, 5), 8'(8'hA0 + i));
		rc(ra(1, 1), 8'h80);
		`CHK(rpid1, 1'b1);
		wr(ra(1, 1), 8'h08);
		`CHK(anyp, 1'b1);
		wr(ra(1, 1), 8'h00);
		repeat (2) @(posedge clk_i);
		`CHK(rpid1, 1'b0);
		host.out_pkt(3'h1, 4, 8'h10, 1'b0);
		rc(ra(1, 1), 8'h10);
		`CHK(ostl, 1'b1);
		wr(ra(1, 1), 8'h04);
		`CHK(ostl, 1'b1);
		wr(ra(1, 1), 8'h00);
		`CHK(ostl, 1'b0);
		wr(ra(1, 0), 8'h04);
		`CHK(istl, 1'b1);
		wr(ra(1, 0), 8'h00);
		$display("test out endpoint done");
		host.point(3'h2);
		wr(ra(2, 2), 8'h02);
		wr(ra(2, 0), 8'h90);
		`CHK(stc, 1'b1);
		wr(ra(2, 5), 8'h5A);
		wr(ra(2, 5), 8'hC3);
		rc(ra(2, 0), 8'hB0);
		`CHK(trdy, 1'b1);
		host.in_pkt(3'h2, 2, 1'b1, hq);
		`CHK(hq, 32'h0000C35A);
		rc(ra(2, 0), 8'h90);
		`CHK(pid1, 1'b1);
		wr(ra(2, 0), 8'h08);
		`CHK(pid1, 1'b0);
		wr(ra(2, 0), 8'h00);
		repeat (2) @(posedge clk_i);
		`CHK(pid1, 1'b0);
		for (int i = 0; i < 2; i++) begin
			wr(ra(2, 5), 8'h11);
			wr(ra(2, 0), 8'h01);
		end
		rc(ra(2, 0), 8'h21);
		wr(ra(2, 0), 8'h40);
		rc(ra(2, 0), 8'h20);
		wr(ra(2, 0), 8'h40);
		rc(ra(2, 0), 8'h00);
		wr(ra(2, 2), 8'h11);
		wr(ra(2, 5), 8'h01);
		wr(ra(2, 0), 8'h01);
		rc(ra(2, 0), 8'h21);
		`CHK(tlen, 8'h01);
		$display("test in endpoint done");
		host.point(3'h4);
		wr(ra(4, 0), 8'h08);
		host.in_pkt(3'h4, 0, 1'b0, hq);
		rc(ra(4, 0), 8'h0A);
		`CHK(irq_n, 1);
		wr(ra(4, 0), 8'h08);
		rc(ra(4, 0), 8'h08);
		wr(ra(4, 3), 8'h01);
		wr(ra(4, 1), 8'h08);
		host.out_pkt(3'h4, 1, 8'h30, 1'b1);
		for (int i = 0; i < 3; i++) host.out_pkt(3'h4, 1, 8'h40, 1'b0);
		rc(ra(4, 1), 8'h2B);
		`CHK(irq_n, 2);
		`CHK(room, 1'b0);
		$display("test iso endpoint done");
		host.out_pkt(3'h0, 2, 8'h80, 1'b0);
		rc(ra(0, 4), 8'h02);
		rc(ra(0, 0), 8'h01);
		wr(ra(0, 0), 8'h40);
		rc(ra(0, 0), 8'h00);
		host.end_ctl();
		rc(ra(0, 0), 8'h20);
		wr(ra(0, 0), 8'h80);
		rc(ra(0, 0), 8'h00);
		$display("test endpoint zero done");
		report_and_stop();
	end
endmodule : tb_usb_endpoint_fifo_control
